// [src/pmt_pkg.sv]
// Shared constants and types for the pulse measurement timer
package pmt_pkg;
   localparam int PMT_AW = 4;
   localparam int PMT_DW = 16;
   localparam int PMT_ST_W = 3;

   // Register offsets
   localparam logic [3:0] PMT_OFF_MODE = 4'h0;
   localparam logic [3:0] PMT_OFF_CSRC = 4'h1;
   localparam logic [3:0] PMT_OFF_TIMER = 4'h2;
   localparam logic [3:0] PMT_OFF_STAT = 4'h3;
   localparam logic [3:0] PMT_OFF_MASK = 4'h4;

   // Mode register fields
   localparam int PMT_MODE_OP_LSB = 0;
   localparam int PMT_MODE_STOP_BIT = 3;
   localparam int PMT_MODE_EDGE_BIT = 5;
   localparam int PMT_MODE_EVT_BIT = 7;
   localparam logic [2:0] PMT_OP_PERIOD = 3'h2;
   localparam logic [2:0] PMT_OP_WIDTH = 3'h3;
   localparam logic [15:0] PMT_MODE_RST = 16'h0000;
   localparam logic [15:0] PMT_MODE_MASK = 16'h00af;

   // Count source register fields
   localparam int PMT_CSRC_SEL_LSB = 0;
   localparam int PMT_CSRC_LOW_BIT = 4;
   localparam logic [3:0] PMT_SRC_SUB = 4'ha;
   localparam logic [15:0] PMT_CSRC_RST = 16'h0003;
   localparam logic [15:0] PMT_CSRC_MASK = 16'h001f;

   // Status and mask bits
   localparam int PMT_ST_DONE_BIT = 0;
   localparam int PMT_ST_REQ_BIT = 1;
   localparam int PMT_ST_UNF_BIT = 2;
   localparam logic [2:0] PMT_STAT_RST = 3'h0;
   localparam logic [2:0] PMT_MASK_RST = 3'h0;

   typedef enum logic [1:0] {
      PMT_ST_IDLE = 2'b00,
      PMT_ST_ARMED = 2'b01,
      PMT_ST_MEAS = 2'b10
   } pmt_state_t;
endpackage : pmt_pkg

// [src/pmt_measurement_timer.sv]
// Pulse period and pulse width measurement timer with register port
//
// Overview of operation
// RQ1: Mode bits 011 with event switch bit clear select pulse width measurement.
// RQ2: Mode bits 010 with event switch bit clear select pulse period measurement.
// RQ3: High or middle speed: main oscillator divided 2..1024, or undivided sub oscillator.
// RQ4: Low speed: sub oscillator divided 2..1024 in powers of two, or undivided.
// RQ5: Width measurement completion sets the measurement timer request flag.
// RQ6: Period measurement completion sets the measurement timer request flag.
// RQ7: Width mode counts high interval, or low interval when edge bit is one.
// RQ8: Period mode counts falling to falling, or rising to rising when edge bit set.
// RQ9: Period mode valid edge latches count complement and reloads all ones.
// RQ10: Width completion edge latches the complement of the current count.
// RQ11: Width start and completion edges both reload the counter with all ones.
// RQ12: Underflow raises the request and reloads all ones in either mode.
// RQ13: Timer reads return the latched value, held until next completion.
// RQ14: Running count unreadable; timer writes only act while stopped.
// RQ15: Software does not write the latch during a measurement.
// RQ16: Software sets the shared port pin carrying the capture input to input.
// RQ17: Enabling measurement does not clear the counter; prior value is kept.
// RQ18: Counter decrements once per selected count source pulse while running.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module pmt_measurement_timer
   import pmt_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int DIV_STAGES = 10
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [PMT_AW-1:0] reg_addr,
   input wire logic [PMT_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [PMT_DW-1:0] reg_rdata,
   input wire logic main_osc_tick,
   input wire logic sub_osc_tick,
   input wire logic capture_input_pin,
   output logic irq
);

   if (CNT_W < 2 || CNT_W > PMT_DW) begin : g_bad_cnt_w
      $error("CNT_W must lie between 2 and the register data width");
   end
   if (DIV_STAGES < 1 || DIV_STAGES > 15) begin : g_bad_div
      $error("DIV_STAGES must lie between 1 and 15");
   end

   logic [PMT_DW-1:0] mode_reg;
   logic [PMT_DW-1:0] csrc_reg;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] meas_latch;
   logic [PMT_ST_W-1:0] stat;
   logic [PMT_ST_W-1:0] mask;
   logic [DIV_STAGES-1:0] div_cnt;
   logic pin_q;
   pmt_state_t state;
   pmt_state_t next_state;
   logic [CNT_W-1:0] next_cnt;
   logic [PMT_ST_W-1:0] next_stat;
   logic [PMT_DW-1:0] next_rdata;

   // Register decode
   wire wr_mode = reg_wr && reg_addr == PMT_OFF_MODE;
   wire wr_csrc = reg_wr && reg_addr == PMT_OFF_CSRC;
   wire wr_timer = reg_wr && reg_addr == PMT_OFF_TIMER;
   wire wr_stat = reg_wr && reg_addr == PMT_OFF_STAT;
   wire wr_mask = reg_wr && reg_addr == PMT_OFF_MASK;

   // Mode decode
   wire [2:0] op = mode_reg[PMT_MODE_OP_LSB +: 3];
   wire evt_sw = mode_reg[PMT_MODE_EVT_BIT];
   wire stop = mode_reg[PMT_MODE_STOP_BIT];
   wire edge_sel = mode_reg[PMT_MODE_EDGE_BIT];
   wire is_width = op == PMT_OP_WIDTH && !evt_sw; // RQ1
   wire is_period = op == PMT_OP_PERIOD && !evt_sw; // RQ2
   wire meas_mode = is_width || is_period;
   wire running = meas_mode && !stop;

   // Count source: one shared divider, its input picked by the speed mode
   wire low_speed = csrc_reg[PMT_CSRC_LOW_BIT];
   wire [3:0] src_sel = csrc_reg[PMT_CSRC_SEL_LSB +: 4];
   wire base_tick = low_speed ? sub_osc_tick : main_osc_tick; // RQ3 RQ4
   wire [DIV_STAGES-1:0] div_pulse;
   genvar k;
   for (k = 0; k < DIV_STAGES; k = k + 1) begin : g_div
      assign div_pulse[k] = base_tick && (&div_cnt[k:0]);
   end
   // Undivided sub oscillator stays selectable in every speed mode
   wire src_pulse = (src_sel == PMT_SRC_SUB) ? sub_osc_tick : // RQ3 RQ4
                    (32'(src_sel) < DIV_STAGES) ? div_pulse[src_sel] : 1'b0;

   // Edge detection on the capture input
   wire pin_rise = capture_input_pin && !pin_q;
   wire pin_fall = !capture_input_pin && pin_q;
   wire width_start = edge_sel ? pin_fall : pin_rise; // RQ7
   wire width_end = edge_sel ? pin_rise : pin_fall; // RQ7
   wire period_edge = edge_sel ? pin_rise : pin_fall; // RQ8

   // Measurement events
   wire start_evt = state == PMT_ST_ARMED && running && (is_width ? width_start : period_edge);
   wire period_done = state == PMT_ST_MEAS && running && is_period && period_edge;
   wire width_done = state == PMT_ST_MEAS && running && is_width && width_end;
   wire done_evt = period_done || width_done;
   wire reload_evt = start_evt || done_evt; // RQ9 RQ11

   // Width mode only counts inside the measured interval; period mode runs
   // from enable, down from whatever the counter held, until the first valid edge reloads all ones
   wire count_en = running && src_pulse &&
                   (is_period ? state != PMT_ST_IDLE : state == PMT_ST_MEAS); // RQ18 RQ17
   wire underflow = count_en && cnt == '0 && !reload_evt;
   wire timer_wr_ok = wr_timer && (!meas_mode || stop); // RQ14

   // Event set vector in status layout
   wire [PMT_ST_W-1:0] set_vec = {underflow, done_evt || underflow, done_evt}; // RQ5 RQ6 RQ12

   always_comb begin
      next_state = state;
      case (state)
         PMT_ST_IDLE: begin
            if (running) begin
               next_state = PMT_ST_ARMED;
            end
         end
         PMT_ST_ARMED: begin
            if (!running) begin
               next_state = PMT_ST_IDLE;
            end else if (start_evt) begin
               next_state = PMT_ST_MEAS;
            end
         end
         PMT_ST_MEAS: begin
            if (!running) begin
               next_state = PMT_ST_IDLE;
            end else if (width_done) begin
               next_state = PMT_ST_ARMED;
            end
         end
         default: begin
            next_state = PMT_ST_IDLE;
         end
      endcase
   end

   always_comb begin
      if (reload_evt) begin
         next_cnt = '1; // RQ9 RQ11
      end else if (timer_wr_ok) begin
         next_cnt = reg_wdata[CNT_W-1:0]; // RQ14
      end else if (count_en) begin
         next_cnt = (cnt == '0) ? '1 : cnt - 1'b1; // RQ12 RQ18
      end else begin
         next_cnt = cnt; // RQ17
      end
   end

   // Set wins over a write-one clear in the same cycle
   assign next_stat = (wr_stat ? (stat & ~reg_wdata[PMT_ST_W-1:0]) : stat) | set_vec;

   // Read mux; measurement modes hide the running count
   wire [PMT_DW-1:0] timer_view = PMT_DW'(meas_mode ? meas_latch : cnt); // RQ13 RQ14
   assign next_rdata = !reg_rd ? '0 :
                       reg_addr == PMT_OFF_MODE ? mode_reg :
                       reg_addr == PMT_OFF_CSRC ? csrc_reg :
                       reg_addr == PMT_OFF_TIMER ? timer_view :
                       reg_addr == PMT_OFF_STAT ? PMT_DW'(stat) :
                       reg_addr == PMT_OFF_MASK ? PMT_DW'(mask) : '0;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg <= PMT_MODE_RST;
         csrc_reg <= PMT_CSRC_RST;
         mask <= PMT_MASK_RST;
      end else begin
         if (wr_mode) begin
            mode_reg <= reg_wdata & PMT_MODE_MASK;
         end
         if (wr_csrc) begin
            csrc_reg <= reg_wdata & PMT_CSRC_MASK;
         end
         if (wr_mask) begin
            mask <= reg_wdata[PMT_ST_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= PMT_ST_IDLE;
         cnt <= '1;
         meas_latch <= '1;
         stat <= PMT_STAT_RST;
         pin_q <= 1'b0;
         div_cnt <= '0;
         reg_rdata <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         stat <= next_stat;
         pin_q <= capture_input_pin;
         reg_rdata <= next_rdata;
         if (base_tick) begin
            div_cnt <= div_cnt + 1'b1;
         end
         if (done_evt) begin
            meas_latch <= ~cnt; // RQ9 RQ10
         end
      end
   end

   assign irq = |(stat & mask);

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_width_start;
      state == PMT_ST_ARMED && running && is_width && width_start;
   endsequence
   sequence s_period_edge_in_meas;
      state == PMT_ST_MEAS && running && is_period && period_edge;
   endsequence

   property p_width_enter;
      (op == PMT_OP_WIDTH && !evt_sw && !stop && state == PMT_ST_IDLE) |=> state == PMT_ST_ARMED;
   endproperty
   a_width_enter: assert property (p_width_enter) else $error("width mode not armed"); // RQ1

   property p_period_enter;
      (op == PMT_OP_PERIOD && !evt_sw && !stop && state == PMT_ST_IDLE) |=> state == PMT_ST_ARMED;
   endproperty
   a_period_enter: assert property (p_period_enter) else $error("period mode not armed"); // RQ2

   property p_div2_source;
      (src_sel == 4'h0 && base_tick && div_cnt[0]) |-> src_pulse;
   endproperty
   a_div2_source: assert property (p_div2_source) else $error("divide by two missing"); // RQ3

   property p_sub_source;
      (low_speed && src_sel == PMT_SRC_SUB) |-> src_pulse == sub_osc_tick;
   endproperty
   a_sub_source: assert property (p_sub_source) else $error("sub source wrong"); // RQ4

   property p_done_flag;
      done_evt |=> stat[PMT_ST_REQ_BIT] && stat[PMT_ST_DONE_BIT];
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("completion flag not set"); // RQ5

   property p_period_done_irq;
      s_period_edge_in_meas |=> stat[PMT_ST_REQ_BIT];
   endproperty
   a_period_done_irq: assert property (p_period_done_irq) else $error("period flag"); // RQ6

   property p_width_start_pol;
      (state == PMT_ST_ARMED && running && is_width && !edge_sel && pin_rise)
         |=> state == PMT_ST_MEAS;
   endproperty
   a_width_start_pol: assert property (p_width_start_pol) else $error("width start edge"); // RQ7

   property p_period_pol;
      (state == PMT_ST_MEAS && running && is_period && edge_sel && pin_fall && !pin_rise)
         |-> !done_evt;
   endproperty
   a_period_pol: assert property (p_period_pol) else $error("period edge polarity"); // RQ8

   property p_period_latch;
      s_period_edge_in_meas |=> meas_latch == ~$past(cnt) && cnt == '1;
   endproperty
   a_period_latch: assert property (p_period_latch) else $error("period latch wrong"); // RQ9

   property p_width_latch;
      width_done |=> meas_latch == ~$past(cnt);
   endproperty
   a_width_latch: assert property (p_width_latch) else $error("width latch wrong"); // RQ10

   property p_width_reload;
      s_width_start |=> cnt == '1 ##1 state == PMT_ST_MEAS || !running;
   endproperty
   a_width_reload: assert property (p_width_reload) else $error("start reload missing"); // RQ11

   property p_underflow;
      underflow |=> cnt == '1 && stat[PMT_ST_REQ_BIT] && stat[PMT_ST_UNF_BIT];
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow handling"); // RQ12

   property p_read_latch;
      (reg_rd && reg_addr == PMT_OFF_TIMER && meas_mode) |=> reg_rdata == PMT_DW'($past(meas_latch));
   endproperty
   a_read_latch: assert property (p_read_latch) else $error("timer read not latch"); // RQ13

   property p_latch_hold;
      !done_evt |=> $stable(meas_latch);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed"); // RQ13

   property p_write_blocked;
      (wr_timer && running && !reload_evt && !count_en) |=> $stable(cnt);
   endproperty
   a_write_blocked: assert property (p_write_blocked) else $error("write while running"); // RQ14

   property p_enable_keeps;
      ($rose(running) && !count_en && !reload_evt && !wr_timer) |=> $stable(cnt);
   endproperty
   a_enable_keeps: assert property (p_enable_keeps) else $error("counter cleared"); // RQ17

   property p_decrement;
      (count_en && cnt != '0 && !reload_evt && !timer_wr_ok) |=> cnt == $past(cnt) - 1'b1;
   endproperty
   a_decrement: assert property (p_decrement) else $error("decrement wrong"); // RQ18

   // Stopping or leaving the mode abandons any measurement in progress
   property p_stop_idle;
      !running |=> state == PMT_ST_IDLE;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("measurement left running"); // RQ14

   property p_write_taken;
      (timer_wr_ok && !reload_evt) |=> cnt == CNT_W'($past(reg_wdata));
   endproperty
   a_write_taken: assert property (p_write_taken) else $error("stopped write lost"); // RQ14

   property p_rdata_idle;
      !reg_rd |=> reg_rdata == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared"); // RQ13

   property p_width_end_pol;
      (state == PMT_ST_MEAS && running && is_width && edge_sel && pin_rise)
         |=> state == PMT_ST_ARMED;
   endproperty
   a_width_end_pol: assert property (p_width_end_pol) else $error("width end edge"); // RQ7

   property p_period_fall;
      (state == PMT_ST_MEAS && running && is_period && !edge_sel && pin_fall) |-> done_evt;
   endproperty
   a_period_fall: assert property (p_period_fall) else $error("period edge missed"); // RQ8

   property p_status_clear;
      (wr_stat && reg_wdata[PMT_ST_DONE_BIT] && !done_evt) |=> !stat[PMT_ST_DONE_BIT];
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared"); // RQ5

endmodule : pmt_measurement_timer

// [testbench/pmt_pulse_src.sv]
// Pulse source model driving the capture input pin
`timescale 1ns/10ps
module pmt_pulse_src (
   input wire logic clk,
   output logic capture_input_pin
);
   initial begin
      capture_input_pin = 1'b0;
   end
   // Called just after a rising edge; the pin is never left floating
   task automatic hold(input logic level, input int cycles);
      capture_input_pin <= level;
      repeat (cycles) @(posedge clk);
   endtask : hold
   // Width: one active interval of w; period: two valid edges w cycles apart
   task automatic frame(input logic period, input logic idle_lvl, input int w);
      if (period) begin
         hold(~idle_lvl, 4);
         hold(idle_lvl, w - 4);
      end
      hold(~idle_lvl, period ? 4 : w);
      hold(idle_lvl, 16);
   endtask : frame
endmodule : pmt_pulse_src

// [testbench/testbench.sv]
// Self-checking bench for the pulse measurement timer
`timescale 1ns/10ps
module testbench;
   import pmt_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [PMT_AW-1:0] reg_addr = '0;
   logic [PMT_DW-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [PMT_DW-1:0] reg_rdata;
   logic main_osc_tick = 1'b1;
   logic sub_osc_tick = 1'b0;
   logic capture_input_pin;
   logic irq;
   logic [PMT_DW-1:0] rv;
   logic [2:0] sub_ph = 3'h0;
   int fail_count = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   // Sub ticks every 8 clocks, so any window of 8k clocks holds exactly k ticks
   always @(posedge clk) begin
      sub_ph <= sub_ph + 3'h1;
      sub_osc_tick <= (sub_ph == 3'h7);
   end
   pmt_measurement_timer u_pmt_measurement_timer (
      .clk(clk),
      .rst_b(rst_b),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .main_osc_tick(main_osc_tick),
      .sub_osc_tick(sub_osc_tick),
      .capture_input_pin(capture_input_pin),
      .irq(irq)
   );
   pmt_pulse_src u_pmt_pulse_src (
      .clk(clk),
      .capture_input_pin(capture_input_pin)
   );
   task automatic conclude();
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic check(input logic [PMT_DW-1:0] seen, input logic [PMT_DW-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // A gap cycle after each strobe keeps one assignment per signal per step
   task automatic wr(input logic [PMT_AW-1:0] a, input logic [PMT_DW-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [PMT_AW-1:0] a, output logic [PMT_DW-1:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      // Sample mid-cycle, while the read data stand
      @(negedge clk);
      d = reg_rdata;
      @(posedge clk);
   endtask : rd
   task automatic t_reset();
      rd(PMT_OFF_MODE, rv);
      check(rv, PMT_MODE_RST);
      rd(PMT_OFF_CSRC, rv);
      check(rv, PMT_CSRC_RST);
      rd(PMT_OFF_TIMER, rv);
      check(rv, 16'hffff);
      rd(PMT_OFF_STAT, rv);
      check(rv, {13'h0, PMT_STAT_RST});
      wr(4'hf, 16'hffff);
      rd(4'hf, rv);
      check(rv, 16'h0000);
      rd(PMT_OFF_MASK, rv);
      check(rv, {13'h0, PMT_MASK_RST});
   endtask : t_reset
   task automatic t_measure(input logic [2:0] op, input logic edge_sel,
         input logic [15:0] csrc, input int w, input logic [15:0] exp);
      logic idle_lvl;
      idle_lvl = (op == PMT_OP_PERIOD) ? ~edge_sel : edge_sel;
      wr(PMT_OFF_MODE, 16'h0008);
      wr(PMT_OFF_CSRC, csrc);
      u_pmt_pulse_src.hold(idle_lvl, 4);
      wr(PMT_OFF_STAT, 16'h0007);
      wr(PMT_OFF_MODE, {10'h0, edge_sel, 2'b00, op});
      repeat (4) @(posedge clk);
      u_pmt_pulse_src.frame(op == PMT_OP_PERIOD, idle_lvl, w);
      rd(PMT_OFF_TIMER, rv);
      check(rv, exp);
      rd(PMT_OFF_TIMER, rv);
      check(rv, exp);
      rd(PMT_OFF_STAT, rv);
      check(rv, 16'h0003);
   endtask : t_measure
   // Preload a small count: refused while running, taken while stopped
   task automatic t_underflow(input logic [15:0] held);
      int i;
      wr(PMT_OFF_CSRC, 16'h000a);
      wr(PMT_OFF_MASK, 16'h0004);
      wr(PMT_OFF_STAT, 16'h0007);
      wr(PMT_OFF_TIMER, 16'h0004);
      repeat (80) @(posedge clk);
      check({15'h0, irq}, 16'h0000);
      wr(PMT_OFF_MODE, 16'h000a);
      wr(PMT_OFF_TIMER, 16'h0004);
      wr(PMT_OFF_MODE, 16'h0002);
      for (i = 0; i < 200 && irq !== 1'b1; i++) begin
         @(posedge clk);
      end
      check({15'h0, irq}, 16'h0001);
      if (irq !== 1'b1) begin
         conclude();
      end
      rd(PMT_OFF_STAT, rv);
      check(rv, 16'h0006);
      rd(PMT_OFF_TIMER, rv);
      check(rv, held);
      wr(PMT_OFF_MASK, 16'h0001);
      check({15'h0, irq}, 16'h0000);
      wr(PMT_OFF_MASK, 16'h0006);
      wr(PMT_OFF_STAT, 16'h0006);
      rd(PMT_OFF_STAT, rv);
      check(rv, 16'h0000);
      check({15'h0, irq}, 16'h0000);
      // Event switch set: not a measurement mode, so the counter is visible
      wr(PMT_OFF_MODE, 16'h008b);
      wr(PMT_OFF_TIMER, 16'h1234);
      rd(PMT_OFF_TIMER, rv);
      check(rv, 16'h1234);
   endtask : t_underflow
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      // Pin edges w clocks apart leave w-1 counting edges; keeping w-1 a whole
      // number of source periods makes the count independent of divider phase
      t_measure(PMT_OP_WIDTH, 1'b0, 16'h0000, 65, 16'h0020);
      t_measure(PMT_OP_WIDTH, 1'b0, 16'h0002, 65, 16'h0008);
      t_measure(PMT_OP_WIDTH, 1'b1, 16'h000a, 65, 16'h0008);
      t_measure(PMT_OP_WIDTH, 1'b0, 16'h0010, 65, 16'h0004);
      t_measure(PMT_OP_PERIOD, 1'b1, 16'h001a, 65, 16'h0008);
      t_measure(PMT_OP_PERIOD, 1'b0, 16'h0001, 65, 16'h0010);
      t_measure(PMT_OP_PERIOD, 1'b0, 16'h0009, 2049, 16'h0002);
      t_underflow(16'h0002);
      conclude();
   end
endmodule : testbench
